// *** rtl/sleep_ctrl_pkg.sv ***
/*
  package for the sleep control unit: register map, field layout, mode
  codes, reset values and wake-up timing.
  assumes a 32-bit apb slave with word-aligned registers on pclk.
*/
package sleep_ctrl_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] ctrl_offset     = 12'h000;
  localparam logic [11:0] status_offset   = 12'h004;
  localparam logic [11:0] standby_offset  = 12'h008;
  localparam logic [11:0] config_offset   = 12'h00c;

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int          sleep_enable_pos = 0;
  localparam int          mode_lsb         = 1;
  localparam logic [7:0]  ctrl_reset       = 8'h00;

  // sleep_mode_select codes
  localparam logic [1:0]  mode_idle        = 2'h0;
  localparam logic [1:0]  mode_standby     = 2'h1;
  localparam logic [1:0]  mode_power_down  = 2'h2;

  // ************************************************************
  // run_in_standby bits, one per gated peripheral
  // ************************************************************
  localparam int          num_gated        = 4;
  localparam int          gate_rtc         = 0;
  localparam int          gate_custom      = 1;
  localparam int          gate_adc         = 2;
  localparam int          gate_capture     = 3;
  localparam logic [3:0]  standby_reset    = 4'h0;

  // config register: main clock kept in standby, brownout wait select
  localparam int          cfg_main_run_pos = 0;
  localparam int          cfg_bod_lsb      = 4;
  localparam logic [1:0]  bod_wait_code    = 2'h3;
  localparam logic [5:0]  config_reset     = 6'h00;

  // ************************************************************
  // wake-up timing
  // ************************************************************
  localparam int          wake_clk_cycles  = 6;
  localparam logic [3:0]  wake_count_init  = 4'(wake_clk_cycles);

  // wake source bit positions
  localparam int          num_wake         = 8;
  localparam int          wk_pin_change    = 0;
  localparam int          wk_periodic      = 1;
  localparam int          wk_volt_mon      = 2;
  localparam int          wk_two_wire      = 3;
  localparam int          wk_custom        = 4;
  localparam int          wk_rtc           = 5;
  localparam int          wk_standby_other = 6;
  localparam int          wk_other         = 7;

  typedef enum logic [3:0] {
    st_active = 4'h1,
    st_sleep  = 4'h2,
    st_wake   = 4'h4,
    st_isr    = 4'h8
  } state_t;

endpackage

// *** rtl/wake_timer.sv ***
/*
  wake-up delay counter: six clock cycles, with the optional oscillator start-up
  and brownout ready waits checked together once the count ends.
  assumes ready inputs synchronous to pclk.
*/
module wake_timer
  import sleep_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        start,
  input  wire logic        need_osc,
  input  wire logic        wait_bod,
  // status from analog side
  input  wire logic        osc_ready,
  input  wire logic        bod_ready,
  // result
  output logic             done
);

  logic [3:0] count_r;
  logic       running_r;

  // ************************************************************
  // cycle counter
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r   <= 4'h0;
      running_r <= 1'b0;
    end else if (start) begin
      count_r   <= wake_count_init;
      running_r <= 1'b1;
    end else if (running_r && count_r != 4'h0) begin
      count_r   <= count_r - 4'h1;
    end else if (done) begin
      running_r <= 1'b0;
    end
  end

  // bod wait only extends; never shortens the fixed delay
  assign done = running_r && count_r == 4'h0 && (!need_osc || osc_ready)
                && (!wait_bod || bod_ready);

endmodule

// *** rtl/sleep_ctrl.sv ***
/*
  sleep control unit: apb registers, mode state machine, clock gating
  and wake-up qualification.
  assumes the cpu pulses sleep_instr for one cycle per sleep instruction
  and honours cpu_run / isr_take; all inputs synchronous to pclk.
*/
module sleep_ctrl
  import sleep_ctrl_pkg::*;
(
  // apb slave
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // cpu side
  input  wire logic                         sleep_instr,
  input  wire logic                         debug_break,
  output logic                              cpu_run,
  output logic                              isr_take,
  // wake sources and peripheral state
  input  wire logic [sleep_ctrl_pkg::num_wake-1:0]  wake_req,
  input  wire logic                         custom_needs_clk,
  input  wire logic                         osc_ready,
  input  wire logic                         bod_ready,
  input  wire logic                         bod_or_wdt_ulp,
  // clock gates
  output logic                              cpu_clk_en,
  output logic                              per_clk_en,
  output logic [sleep_ctrl_pkg::num_gated-1:0]      gated_clk_en,
  output logic                              main_osc_en,
  output logic                              ulp_osc_en,
  output logic                              rtc_clk_en
);

  import sleep_ctrl_pkg::*;

  state_t      state_r, state_nxt;
  logic [7:0]  ctrl_r;
  logic [3:0]  standby_r;
  logic [5:0]  config_r;
  logic [1:0]  mode_r;
  logic        wake_by_irq_r;
  logic        wake_start;
  logic        wake_done;
  logic        wake_any;
  logic        need_osc;
  logic [1:0]  eff_mode;
  logic [num_wake-1:0] wake_mask;
  logic        wr_access;
  logic        rd_access;

  // ************************************************************
  // apb access
  // ************************************************************
  // single-cycle access: pready answers in the access phase itself
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && !penable && !pwrite;

  // reserved code maps to idle so gating never sees an undefined mode
  assign eff_mode = (ctrl_r[mode_lsb +: 2] == mode_standby ||
                     ctrl_r[mode_lsb +: 2] == mode_power_down)
                    ? ctrl_r[mode_lsb +: 2] : mode_idle;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= ctrl_reset;
      standby_r <= standby_reset;
      config_r  <= config_reset;
    end else if (wr_access) begin
      unique case (paddr)
        ctrl_offset:    ctrl_r    <= {5'h00, pwdata[2:0]};
        standby_offset: standby_r <= pwdata[3:0];
        config_offset:  config_r  <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == ctrl_offset || paddr == status_offset ||
                 paddr == standby_offset || paddr == config_offset);
      if (rd_access) begin
        unique case (paddr)
          ctrl_offset:    prdata <= {24'h00_0000, ctrl_r};
          status_offset:  prdata <= {26'h000_0000, mode_r, 4'(state_r)};
          standby_offset: prdata <= {28'h000_0000, standby_r};
          config_offset:  prdata <= {26'h000_0000, config_r};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ************************************************************
  // wake source qualification
  // ************************************************************
  always_comb begin
    wake_mask = '0;
    unique case (mode_r)
      mode_standby: begin
        wake_mask[wk_pin_change]    = 1'b1;
        wake_mask[wk_periodic]      = 1'b1;
        wake_mask[wk_volt_mon]      = 1'b1;
        wake_mask[wk_two_wire]      = 1'b1;
        wake_mask[wk_custom]        = standby_r[gate_custom];
        wake_mask[wk_rtc]           = standby_r[gate_rtc];
        wake_mask[wk_standby_other] = |standby_r;
      end
      mode_power_down: begin
        wake_mask[wk_pin_change]    = 1'b1;
        wake_mask[wk_periodic]      = 1'b1;
        wake_mask[wk_volt_mon]      = 1'b1;
        wake_mask[wk_two_wire]      = 1'b1;
        wake_mask[wk_custom]        = !custom_needs_clk;
      end
      default: wake_mask = '1;
    endcase
  end

  // without enabled sources only debug or reset can leave sleep
  assign wake_any   = |(wake_req & wake_mask);
  assign wake_start = state_r == st_sleep && (wake_any || debug_break);
  assign need_osc   = mode_r != mode_idle &&
                      !(mode_r == mode_standby && config_r[cfg_main_run_pos]);

  wake_timer u_wake_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (wake_start),
    .need_osc  (need_osc),
    .wait_bod  (config_r[cfg_bod_lsb +: 2] == bod_wait_code),
    .osc_ready (osc_ready),
    .bod_ready (bod_ready),
    .done      (wake_done)
  );

  // ************************************************************
  // mode state machine
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_active: if (sleep_instr && ctrl_r[sleep_enable_pos]) state_nxt = st_sleep;
      st_sleep:  if (wake_start) state_nxt = st_wake;
      st_wake:   if (wake_done) state_nxt = wake_by_irq_r ? st_isr : st_active;
      st_isr:    state_nxt = st_active;
    endcase
  end

  // reset returns to active from any state, i.e. the reset vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= st_active;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r        <= mode_idle;
      wake_by_irq_r <= 1'b0;
    end else begin
      if (state_r == st_active && sleep_instr && ctrl_r[sleep_enable_pos]) begin
        mode_r <= eff_mode;
      end
      if (wake_start) begin
        wake_by_irq_r <= wake_any;
      end
    end
  end

  // ************************************************************
  // clock gating outputs, all registered
  // ************************************************************
  // gating only stops clocks; no state is cleared, so contents persist
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en   <= 1'b1;
      per_clk_en   <= 1'b1;
      gated_clk_en <= '1;
      main_osc_en  <= 1'b1;
      ulp_osc_en   <= 1'b1;
      rtc_clk_en   <= 1'b1;
      cpu_run      <= 1'b1;
      isr_take     <= 1'b0;
    end else begin
      cpu_run  <= state_nxt == st_active || state_nxt == st_isr;
      cpu_clk_en <= state_nxt != st_sleep && state_nxt != st_wake;
      isr_take <= state_nxt == st_isr;
      if (state_nxt == st_sleep) begin
        // mode_r lands on the entry edge itself, so entry must use the fresh decode
        unique case (state_r == st_active ? eff_mode : mode_r)
          mode_standby: begin
            per_clk_en   <= 1'b0;
            gated_clk_en <= standby_r;
            main_osc_en  <= config_r[cfg_main_run_pos];
            ulp_osc_en   <= 1'b1;
            rtc_clk_en   <= standby_r[gate_rtc];
          end
          mode_power_down: begin
            per_clk_en   <= 1'b0;
            gated_clk_en <= '0;
            main_osc_en  <= 1'b0;
            ulp_osc_en   <= bod_or_wdt_ulp;
            rtc_clk_en   <= bod_or_wdt_ulp;
          end
          default: begin
            per_clk_en   <= 1'b1;
            gated_clk_en <= '1;
            main_osc_en  <= 1'b1;
            ulp_osc_en   <= 1'b1;
            rtc_clk_en   <= 1'b1;
          end
        endcase
      end else begin
        per_clk_en   <= 1'b1;
        gated_clk_en <= '1;
        main_osc_en  <= 1'b1;
        ulp_osc_en   <= 1'b1;
        rtc_clk_en   <= 1'b1;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_sleep_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_active && sleep_instr && !ctrl_r[sleep_enable_pos] |=> state_r == st_active)
    else $error("sleep entered with enable clear");

  a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_active && sleep_instr && ctrl_r[sleep_enable_pos] |=> state_r == st_sleep)
    else $error("sleep not entered");

  a_cpu_stops: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_sleep |-> !cpu_clk_en && !cpu_run)
    else $error("cpu clock running in sleep");

  a_wake_min_delay: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_sleep && wake_start |=> state_r == st_wake [*6])
    else $error("wake shorter than six cycles");

  a_debug_wakes: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_sleep && debug_break |=> state_r == st_wake)
    else $error("debug break did not wake");

  a_pd_main_off: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_sleep && mode_r == mode_power_down |-> !main_osc_en && !per_clk_en)
    else $error("main clock on in power-down");

  a_standby_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_sleep && mode_r == mode_standby |-> gated_clk_en == $past(standby_r))
    else $error("standby gating mismatch");

  a_irq_isr: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_isr |-> isr_take ##1 state_r == st_active)
    else $error("handler step missing");

  a_reserved_idle: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_sleep |-> mode_r != 2'h3)
    else $error("reserved mode stored");

  a_bod_wait_holds: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_wake && config_r[cfg_bod_lsb +: 2] == bod_wait_code && !bod_ready
    |=> state_r == st_wake)
    else $error("wake ended before brownout ready");

  a_osc_wait_holds: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_wake && need_osc && !osc_ready |=> state_r == st_wake)
    else $error("wake ended before oscillator ready");

  a_idle_clocks_on: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == st_sleep && mode_r == mode_idle |-> per_clk_en && main_osc_en && &gated_clk_en)
    else $error("idle sleep stopped a clock");

endmodule

// *** dv/cpu_model.sv ***
/*
  behavioural cpu core in front of the sleep control unit: turns a
  bench request into a one-cycle sleep instruction and counts handler
  entries.
  assumes pclk and presetn from the bench.
*/
module cpu_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench command
  input  wire logic want_sleep,
  // sleep control side
  input  wire logic cpu_run,
  input  wire logic isr_take,
  output logic      sleep_instr,
  output int        isr_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // sleep instruction
  // ************************************************************
  // only a running core executes; bench sets mode and enable first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr <= 1'b0;
    end else begin
      sleep_instr <= want_sleep & cpu_run & ~sleep_instr;
    end
  end

  // ************************************************************
  // handler entries
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_cnt <= 0;
    end else if (isr_take === 1'b1) begin
      isr_cnt <= isr_cnt + 1;
    end
  end
endmodule

// *** dv/sleep_ctrl_tb.sv ***
/*
  self-checking bench for the sleep control unit: table of sleep and
  wake cases, then refusal, power-down wake filter, debug, stall and reset-in-sleep tests.
  assumes cpu_model beside the design; one clock at 250 mhz.
*/
module sleep_ctrl_tb
  import sleep_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [1:0] mode;
    logic [3:0] sby;
    logic [5:0] cfg;
    logic       ulp;
    logic       osc;
    int         wk;
    logic [2:0] en;
    logic [3:0] gt;
  } row_t;

  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                sleep_instr, debug_break, cpu_run, isr_take, want_sleep;
  logic [num_wake-1:0] wake_req;
  logic                custom_needs_clk, osc_ready, bod_ready, bod_or_wdt_ulp;
  logic                cpu_clk_en, per_clk_en, main_osc_en, ulp_osc_en, rtc_clk_en;
  logic [3:0]          gated_clk_en;
  int                  isr_cnt, n_fail, checked, n, n0;
  row_t                rows[8];
  row_t                r;

  sleep_ctrl i_sleep_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_instr(sleep_instr), .debug_break(debug_break),
    .cpu_run(cpu_run), .isr_take(isr_take), .wake_req(wake_req),
    .custom_needs_clk(custom_needs_clk), .osc_ready(osc_ready), .bod_ready(bod_ready),
    .bod_or_wdt_ulp(bod_or_wdt_ulp), .cpu_clk_en(cpu_clk_en), .per_clk_en(per_clk_en),
    .gated_clk_en(gated_clk_en), .main_osc_en(main_osc_en), .ulp_osc_en(ulp_osc_en),
    .rtc_clk_en(rtc_clk_en));

  cpu_model i_cpu_model (.pclk(pclk), .presetn(presetn), .want_sleep(want_sleep),
    .cpu_run(cpu_run), .isr_take(isr_take), .sleep_instr(sleep_instr), .isr_cnt(isr_cnt));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk(0, 1, "apb answer");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go_sleep;
    @(posedge pclk);
    want_sleep <= 1'b1;
    @(posedge pclk);
    want_sleep <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // bounded wait for the core to run again
  task automatic wait_run;
    n = 0;
    while (cpu_run !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) chk(0, 1, "wake timeout");
  endtask

  // wake held back by a missing ready signal
  task automatic stall(input logic [1:0] m, input logic [5:0] c, input logic brownout_detector);
    apb(1, config_offset, 32'(c));
    apb(1, ctrl_offset, {29'h0, m, 1'b1});
    osc_ready <= brownout_detector;
    bod_ready <= !brownout_detector;
    go_sleep();
    wake_req[wk_pin_change] <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(32'(cpu_run), 0, "wake before ready");
    osc_ready <= 1'b1;
    bod_ready <= 1'b1;
    wait_run();
    wake_req <= '0;
    repeat (2) @(posedge pclk);
    apb(1, config_offset, 32'h0);
    $display("test stall done");
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    #100000;
    n_fail++;
    stop_test();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, want_sleep, debug_break} = '0;
    {wake_req, custom_needs_clk, bod_or_wdt_ulp} = '0;
    {osc_ready, bod_ready} = 2'b11;
    rows = '{
      '{mode_idle, 4'h0, 6'h00, 1'b0, 1'b0, wk_other, 3'b111, 4'hf},
      '{mode_standby, 4'h5, 6'h01, 1'b0, 1'b0, wk_rtc, 3'b010, 4'h5},
      '{mode_standby, 4'ha, 6'h00, 1'b0, 1'b1, wk_pin_change, 3'b000, 4'ha},
      '{mode_power_down, 4'hf, 6'h00, 1'b1, 1'b1, wk_two_wire, 3'b001, 4'h0},
      '{mode_power_down, 4'h0, 6'h00, 1'b0, 1'b1, wk_volt_mon, 3'b000, 4'h0},
      '{mode_power_down, 4'h0, 6'h00, 1'b0, 1'b1, wk_custom, 3'b000, 4'h0},
      '{mode_power_down, 4'h0, 6'h00, 1'b0, 1'b1, wk_periodic, 3'b000, 4'h0},
      '{2'h3, 4'h0, 6'h00, 1'b0, 1'b0, wk_other, 3'b111, 4'hf}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      bod_or_wdt_ulp <= r.ulp;
      osc_ready <= r.osc;
      apb(1, standby_offset, 32'(r.sby));
      apb(1, config_offset, 32'(r.cfg));
      apb(1, ctrl_offset, {29'h0, r.mode, 1'b1});
      n0 = isr_cnt;
      go_sleep();
      chk(32'({cpu_run, cpu_clk_en}), 0, "cpu clock in sleep");
      chk(32'({per_clk_en, main_osc_en}), 32'(r.en[2:1]), "clock enables");
      chk(32'(gated_clk_en), 32'(r.gt), "gated clocks");
      if (r.mode == mode_standby) begin
        chk(32'({ulp_osc_en, rtc_clk_en}), 32'({1'b1, r.sby[gate_rtc]}),
            "standby clocks");
      end else begin
        chk(32'({ulp_osc_en, rtc_clk_en}), {30'h0, {2{r.en[0]}}},
            "low power clocks");
      end
      wake_req[r.wk] <= 1'b1;
      wait_run();
      wake_req <= '0;
      chk(32'(n >= 7), 1, "wake delay");
      repeat (2) @(posedge pclk);
      chk(32'(isr_cnt - n0), 1, "handler once");
    end
    $display("test table done");
    apb(1, config_offset, 32'h0);
    apb(1, standby_offset, 32'h0);
    apb(0, 12'h010, 32'h0);
    chk({rd[30:0], er}, 1, "unmapped refused");
    apb(1, ctrl_offset, 32'h4);
    go_sleep();
    chk(32'({cpu_run, cpu_clk_en}), 3, "disabled sleep");
    $display("test refusal done");
    apb(1, ctrl_offset, 32'h5);
    custom_needs_clk <= 1'b1;
    go_sleep();
    wake_req <= 8'h80 | 8'h20 | 8'h10;
    repeat (20) @(posedge pclk);
    chk(32'(cpu_run), 0, "power-down wake filter");
    apb(0, status_offset, 32'h0);
    chk(rd, 32'h22, "status asleep");
    apb(0, ctrl_offset, 32'h0);
    chk(rd, 32'h5, "ctrl kept");
    wake_req <= '0;
    custom_needs_clk <= 1'b0;
    // last table row left the oscillator unready; power-down wake would hang
    osc_ready <= 1'b1;
    n0 = isr_cnt;
    debug_break <= 1'b1;
    @(posedge pclk);
    debug_break <= 1'b0;
    wait_run();
    repeat (2) @(posedge pclk);
    chk(32'(isr_cnt - n0), 0, "debug wake no handler");
    $display("test debug done");
    stall(mode_standby, 6'h00, 1'b0);
    stall(mode_idle, 6'h30, 1'b1);
    apb(1, ctrl_offset, 32'h1);
    go_sleep();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'({cpu_run, cpu_clk_en, per_clk_en}), 7, "reset ends sleep");
    presetn <= 1'b1;
    apb(0, status_offset, 32'h0);
    chk(rd, 32'h1, "active after reset");
    apb(0, ctrl_offset, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    $display("test reset done");
    stop_test();
  end
endmodule
